// file: logic/radio_serial_control_regs.sv
// Write-only serial control register bank of the radio transceiver.
`timescale 1ns/1ps
`default_nettype none

module radio_serial_control_regs
    import rsc_pkg::*;
(
    // System.
    input  wire logic       clock,
    input  wire logic       reset,
    // Serial programming pins.
    input  wire logic       serialClock,
    input  wire logic       serialData,
    input  wire logic       loadStrobe,
    // Transceiver control pins and status.
    input  wire logic       receiveOn,
    input  wire logic       supplyLow,
    input  wire logic       paRequest,
    input  wire logic       rxData,
    input  wire rsc_probe_t probeSrc,
    // Pin outputs.
    output logic            paEnableOut,
    output logic            rxDataOut,
    output logic            auxPinOut,
    output logic            auxPinOe,
    output logic            lowvoltLockout,
    output logic            rfBufferOn,
    output logic            analogTestMode,
    output logic            digitalTestMode,
    output rsc_ctrl_t       ctrl
);

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    // Every serial, receive and supply pin passes two flops; only the second stage is read.
    // The stages reset to the idle pin levels. A strobe that sat low in
    // reset and then rose to its idle high level would look like a load
    // and write the empty shift register into the configuration word.
    logic [4:0] syncA_reg;
    logic [4:0] syncB_reg;
    logic       sClkD_reg;
    logic       strobeD_reg;
    logic       rxOnD_reg;
    logic       sClk;
    logic       sData;
    logic       strobe;
    logic       receive_on;
    logic       lowSupply;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            syncA_reg <= SYNC_IDLE;
            syncB_reg <= SYNC_IDLE;
        end
        else
        begin
            syncA_reg <= {supplyLow, receiveOn, loadStrobe, serialData,
                          serialClock};
            syncB_reg <= syncA_reg;
        end
    end

    assign sClk      = syncB_reg[0];
    assign sData     = syncB_reg[1];
    assign strobe    = syncB_reg[2];
    assign receive_on      = syncB_reg[3];
    assign lowSupply = syncB_reg[4];

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            sClkD_reg   <= SYNC_IDLE[0];
            strobeD_reg <= SYNC_IDLE[2];
            rxOnD_reg   <= SYNC_IDLE[3];
        end
        else
        begin
            sClkD_reg   <= sClk;
            strobeD_reg <= strobe;
            rxOnD_reg   <= receive_on;
        end
    end

    // Edges are found on the synchronised copies only. The extra flop
    // adds no latency, since the rise and fall flags are combinational; every pin level must still last
    // at least three clocks; a faster host would lose bits.
    logic sClkRise;
    logic strobeRise;
    logic rxOnFall;
    logic rxOnRise;

    assign sClkRise   = sClk & ~sClkD_reg;
    assign strobeRise = strobe & ~strobeD_reg;
    assign rxOnFall   = ~receive_on & rxOnD_reg;
    assign rxOnRise   = receive_on & ~rxOnD_reg;

    // ==========================================================
    // Shift register
    // ==========================================================
    // Data and address arrive MSB first, so the word shifts in at the
    // bottom and the newest sixteen bits are always held.
    // There is no bit counter: a short word is not refused, it simply
    // mixes with older bits, so the host must always send sixteen.
    logic [WORD_BITS-1:0] shift_reg;

    always_ff @(posedge clock)
    begin
        if (reset)
            shift_reg <= REG_RESET;
        else if (sClkRise && !strobe)
            shift_reg <= {shift_reg[WORD_BITS-2:0], sData};
    end

    // ==========================================================
    // Register load
    // ==========================================================
    // Registers drive the core and the pins; nothing reads them back.
    logic [WORD_BITS-1:0] pllConfig_reg;
    logic [WORD_BITS-1:0] channelDivide_reg;
    logic [WORD_BITS-1:0] testSelect_reg;
    logic [1:0]           wordAddr;

    assign wordAddr = shift_reg[ADDR_MSB:ADDR_LSB];

    // The whole word, address included, is stored. Keeping the address
    // bits costs two flops per register but keeps the load a plain copy.

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            pllConfig_reg     <= REG_RESET;
            channelDivide_reg <= REG_RESET;
            testSelect_reg    <= REG_RESET;
        end
        else if (strobeRise)
        begin
            unique case (wordAddr)
                ADDR_PLL_CONFIG:     pllConfig_reg     <= shift_reg;
                ADDR_CHANNEL_DIVIDE: channelDivide_reg <= shift_reg;
                ADDR_TEST_SELECT:    testSelect_reg    <= shift_reg;
                default:             ;
            endcase
        end
    end

    // ==========================================================
    // Decoded controls
    // ==========================================================
    rsc_aprobe_t aProbe;
    rsc_dprobe_t dProbe;

    assign aProbe = rsc_aprobe_t'(testSelect_reg[APROBE_MSB:APROBE_LSB]);
    assign dProbe = rsc_dprobe_t'(testSelect_reg[DPROBE_MSB:DPROBE_LSB]);

    always_comb
    begin
        ctrl.pumpPolarity      = pllConfig_reg[BIT_PUMP_POLARITY];
        ctrl.refDivRatio       = pllConfig_reg[BIT_REF_DIV_SELECT]
                               ? REF_DIV_HIGH : REF_DIV_LOW;
        ctrl.analogAuxOut      = pllConfig_reg[BIT_ANALOG_AUX_OUT];
        // Carrier-only applies in transmit only.
        ctrl.carrierOnlyTest   = pllConfig_reg[BIT_CARRIER_ONLY] & ~receive_on;
        ctrl.rfBufferTiming    = pllConfig_reg[BIT_RF_BUF_TIMING];
        ctrl.signalClipDisable = pllConfig_reg[BIT_CLIP_DISABLE];
        ctrl.channelDivide     =
            channelDivide_reg[CHAN_MSB:CHAN_LSB];
        ctrl.analogProbeSel    = aProbe;
        ctrl.digitalProbeSel   = dProbe;
    end

    assign analogTestMode  = (aProbe != APROBE_NORMAL);
    assign digitalTestMode = (dProbe != DPROBE_NORMAL);

    // ==========================================================
    // Low-voltage lockout
    // ==========================================================
    // The latch is level set by the enabled low-supply indication and
    // cleared by the start of a receive slot. Set wins when both meet,
    // so a supply still low at the slot change keeps the PA off, except in DPROBE_SDM where the PA pin carries sdmLsb.
    logic lockout_reg;

    always_ff @(posedge clock)
    begin
        if (reset)
            lockout_reg <= 1'b0;
        else if (pllConfig_reg[BIT_LOWVOLT_LOCKOUT] && lowSupply)
            lockout_reg <= 1'b1;
        else if (rxOnRise)
            lockout_reg <= 1'b0;
    end

    assign lowvoltLockout = lockout_reg;

    // ==========================================================
    // Auxiliary open-drain pin
    // ==========================================================
    // The power control bit is sampled once per transmit slot so a write
    // mid-slot cannot glitch the external PA gain.
    logic txPower_reg;

    always_ff @(posedge clock)
    begin
        if (reset)
            txPower_reg <= 1'b0;
        else if (rxOnFall)
            txPower_reg <= pllConfig_reg[BIT_TX_POWER_CTL];
    end

    assign auxPinOut = 1'b0;
    // Drive low only in power control mode with no probe routed.
    assign auxPinOe  = txPower_reg & ~pllConfig_reg[BIT_ANALOG_AUX_OUT]
                     & ~analogTestMode;

    // ==========================================================
    // Digital pins and probe multiplexer
    // ==========================================================
    // Both pins are registered so the probe multiplexer cannot glitch
    // them; the cost is one clock of delay on the data path.
    logic paNormal;
    logic paNext;
    logic rxNext;
    logic paOut_reg;
    logic rxOut_reg;

    assign paNormal = paRequest & ~lockout_reg;

    always_comb
    begin
        paNext = paNormal;
        rxNext = rxData;
        unique case (dProbe)
            DPROBE_AGC:     rxNext = probeSrc.agcSwitch;
            DPROBE_MAINDIV: rxNext = probeSrc.mainDivOut;
            DPROBE_REFDIV:  rxNext = probeSrc.refDivOut;
            DPROBE_SDM:
            begin
                rxNext = probeSrc.sdmMsb;
                paNext = probeSrc.sdmLsb;
            end
            default:        ;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            paOut_reg <= 1'b0;
            rxOut_reg <= 1'b0;
        end
        else
        begin
            paOut_reg <= paNext;
            rxOut_reg <= rxNext;
        end
    end

    assign paEnableOut = paOut_reg;
    assign rxDataOut   = rxOut_reg;
    // Buffer follows the PA enable in timing mode, else on through transmit.
    assign rfBufferOn  = pllConfig_reg[BIT_RF_BUF_TIMING] ? paOut_reg
                                                          : ~receive_on;

endmodule

`default_nettype wire

// file: logic/rsc_pkg.sv
// Package of constants and types for the radio serial control registers.
package rsc_pkg;

    // Serial word layout.
    localparam int WORD_BITS = 16;
    localparam int ADDR_LSB  = 0;
    localparam int ADDR_MSB  = 1;

    // Register addresses carried in the two last bits of a word.
    localparam logic [1:0] ADDR_PLL_CONFIG     = 2'h0;
    localparam logic [1:0] ADDR_CHANNEL_DIVIDE = 2'h1;
    localparam logic [1:0] ADDR_TEST_SELECT    = 2'h2;

    localparam logic [15:0] REG_RESET = 16'h0000;

    // Idle levels of the synchronised pins, strobe high, in pin order.
    localparam logic [4:0] SYNC_IDLE = 5'h04;

    // PLL configuration field positions.
    localparam int BIT_PUMP_POLARITY   = 2;
    localparam int BIT_REF_DIV_SELECT  = 3;
    localparam int BIT_ANALOG_AUX_OUT  = 4;
    localparam int BIT_CARRIER_ONLY    = 6;
    localparam int BIT_TX_POWER_CTL    = 7;
    localparam int BIT_RF_BUF_TIMING   = 8;
    localparam int BIT_LOWVOLT_LOCKOUT = 10;
    localparam int BIT_CLIP_DISABLE    = 11;

    // Channel and test field positions.
    localparam int CHAN_LSB   = 2;
    localparam int CHAN_MSB   = 13;
    localparam int APROBE_LSB = 2;
    localparam int APROBE_MSB = 4;
    localparam int DPROBE_LSB = 5;
    localparam int DPROBE_MSB = 7;

    // Reference divider ratios.
    localparam logic [4:0] REF_DIV_LOW  = 5'h09;
    localparam logic [4:0] REF_DIV_HIGH = 5'h12;

    typedef enum logic [2:0] {
        APROBE_NORMAL   = 3'h0,
        APROBE_OPEN     = 3'h1,
        APROBE_IF_IQ    = 3'h2,
        APROBE_IF_Q_DIF = 3'h3,
        APROBE_IF_I_DIF = 3'h4,
        APROBE_DATAFILT = 3'h5,
        APROBE_LIMITER  = 3'h6,
        APROBE_REF_MOD  = 3'h7
    } rsc_aprobe_t;

    typedef enum logic [2:0] {
        DPROBE_NORMAL  = 3'h0,
        DPROBE_AGC     = 3'h1,
        DPROBE_MAINDIV = 3'h2,
        DPROBE_REFDIV  = 3'h3,
        DPROBE_SDM     = 3'h4
    } rsc_dprobe_t;

    // Decoded controls sent to the analog core.
    typedef struct packed {
        logic        pumpPolarity;
        logic [4:0]  refDivRatio;
        logic        analogAuxOut;
        logic        carrierOnlyTest;
        logic        rfBufferTiming;
        logic        signalClipDisable;
        logic [11:0] channelDivide;
        rsc_aprobe_t analogProbeSel;
        rsc_dprobe_t digitalProbeSel;
    } rsc_ctrl_t;

    // Digital test sources from the core.
    typedef struct packed {
        logic agcSwitch;
        logic mainDivOut;
        logic refDivOut;
        logic sdmMsb;
        logic sdmLsb;
    } rsc_probe_t;

endpackage

// file: bench/rsc_regs_chk.sv
// Assertion checker for the radio serial control register bank.
`timescale 1ns/1ps
`default_nettype none
module rsc_regs_chk
    import rsc_pkg::*;
(
    // System.
    input wire logic       clock,
    input wire logic       reset,
    // Core side.
    input wire logic       rxData,
    input wire rsc_probe_t probeSrc,
    // Pins and decoded controls.
    input wire logic       paEnableOut,
    input wire logic       rxDataOut,
    input wire logic       auxPinOut,
    input wire logic       auxPinOe,
    input wire logic       lowvoltLockout,
    input wire logic       rfBufferOn,
    input wire logic       analogTestMode,
    input wire logic       digitalTestMode,
    input wire rsc_ctrl_t  ctrl
);
    logic probeBit;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    // The receive data pin is registered, so it shows last cycle's source.
    always_comb
    begin
        case (ctrl.digitalProbeSel)
            DPROBE_AGC:     probeBit = probeSrc.agcSwitch;
            DPROBE_MAINDIV: probeBit = probeSrc.mainDivOut;
            DPROBE_REFDIV:  probeBit = probeSrc.refDivOut;
            DPROBE_SDM:     probeBit = probeSrc.sdmMsb;
            default:        probeBit = rxData;
        endcase
    end

    // ==========
    // Pin and control checks
    chk_aux_never_high: assert property (auxPinOut == 1'b0)
        else $error("aux pin data not low");
    chk_aux_mode_gate: assert property (
        auxPinOe |-> !ctrl.analogAuxOut && !analogTestMode)
        else $error("aux pin pulled in wrong mode");
    chk_ref_div_ratio: assert property (
        ctrl.refDivRatio == REF_DIV_LOW || ctrl.refDivRatio == REF_DIV_HIGH)
        else $error("bad reference ratio");
    chk_analog_test_mode: assert property (
        analogTestMode == (ctrl.analogProbeSel != APROBE_NORMAL))
        else $error("analog test mode wrong");
    chk_digital_test_mode: assert property (
        digitalTestMode == (ctrl.digitalProbeSel != DPROBE_NORMAL))
        else $error("digital test mode wrong");
    chk_lockout_pa_off: assert property (
        (lowvoltLockout && !digitalTestMode) [*2] |-> !paEnableOut)
        else $error("PA on during lockout");
    chk_buffer_follows_pa: assert property (
        ctrl.rfBufferTiming |-> rfBufferOn == paEnableOut)
        else $error("RF buffer not following PA");
    chk_rx_source: assert property (
        !$past(reset) && $past(ctrl.digitalProbeSel) <= DPROBE_SDM
        |-> rxDataOut == $past(probeBit))
        else $error("receive data source wrong");
    chk_sdm_lsb_pa: assert property (
        !$past(reset) && $past(ctrl.digitalProbeSel) == DPROBE_SDM
        |-> paEnableOut == $past(probeSrc.sdmLsb))
        else $error("PA pin not sigma-delta LSB");
endmodule
`default_nettype wire

// file: bench/rsc_host.sv
// Host model that shifts words into the serial programming pins.
`timescale 1ns/1ps
`default_nettype none
module rsc_host (
    // System.
    input  wire logic clock,
    // Serial programming pins.
    output var logic  serialClock,
    output var logic  serialData,
    output var logic  loadStrobe
);
    initial
    begin
        serialClock = 1'b0;
        serialData  = 1'b0;
        loadStrobe  = 1'b1;
    end

    // Four clocks a level, since the pins pass a two-flop synchroniser.
    task automatic hold();
        repeat (4) @(posedge clock);
    endtask

    task automatic send_word(input logic [15:0] w, input logic load);
        loadStrobe <= 1'b0;
        hold();
        for (int i = 15; i >= 0; i--)
        begin
            serialData  <= w[i];
            serialClock <= 1'b0;
            hold();
            serialClock <= 1'b1;
            hold();
        end
        serialClock <= 1'b0;
        serialData  <= ~w[0];
        hold();
        if (load)
        begin
            loadStrobe <= 1'b1;
            hold();
        end
    endtask
endmodule
`default_nettype wire

// file: bench/tb_radio_serial_control_regs.sv
// Self-checking testbench for the radio serial control register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_radio_serial_control_regs;
    import rsc_pkg::*;
    localparam logic [15:0] MASKS [4] = '{16'h0DDC, 16'h3FFC, 16'h001C,
                                         16'h0000};
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        receiveOn = 1'b1;
    logic        supplyLow = 1'b0;
    logic        paRequest = 1'b0;
    logic        rxData = 1'b0;
    rsc_probe_t  probeSrc = '0;
    logic        serialClock, serialData, loadStrobe, paEnableOut, rxDataOut;
    logic        auxPinOut, auxPinOe, lowvoltLockout, rfBufferOn;
    logic        analogTestMode, digitalTestMode;
    rsc_ctrl_t   ctrl;
    logic [31:0] seed = 32'hA48D31DB;
    logic [15:0] regs [3] = '{default: 16'h0000};
    logic [15:0] w;
    int          nMismatch = 0;
    int          samplesChecked = 0;

    always #25 clock = ~clock;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    always @(posedge clock) {paRequest, rxData, probeSrc} <= 7'(rnd());

    rsc_host u_host (.clock(clock), .serialClock(serialClock),
        .serialData(serialData), .loadStrobe(loadStrobe));

    radio_serial_control_regs u_dut (.clock(clock), .reset(reset),
        .serialClock(serialClock), .serialData(serialData),
        .loadStrobe(loadStrobe), .receiveOn(receiveOn),
        .supplyLow(supplyLow), .paRequest(paRequest), .rxData(rxData),
        .probeSrc(probeSrc), .paEnableOut(paEnableOut),
        .rxDataOut(rxDataOut), .auxPinOut(auxPinOut), .auxPinOe(auxPinOe),
        .lowvoltLockout(lowvoltLockout), .rfBufferOn(rfBufferOn),
        .analogTestMode(analogTestMode), .digitalTestMode(digitalTestMode),
        .ctrl(ctrl));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_all();
        rsc_ctrl_t e;
        e = {regs[0][2], regs[0][3] ? REF_DIV_HIGH : REF_DIV_LOW, regs[0][4],
             regs[0][6] & ~receiveOn, regs[0][8], regs[0][11],
             regs[1][13:2], regs[2][4:2], regs[2][7:5]};
        check(ctrl, e);
        check(analogTestMode, |regs[2][4:2]);
        check(digitalTestMode, |regs[2][7:5]);
    endtask

    task automatic wr_reg(input logic [15:0] v);
        u_host.send_word(v, 1'b1);
        if (v[1:0] != 2'h3)
            regs[v[1:0]] = v;
        repeat (6) @(posedge clock);
        check_all();
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", samplesChecked, nMismatch);
        if (nMismatch == 0 && samplesChecked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clock);
        nMismatch++;
        tally_and_finish();
    end

    initial
    begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        check_all();
        $display("test reset done");
        for (int i = 0; i < 8; i++)
            wr_reg({8'h00, 3'(i < 5 ? i : 0), 3'(i), 2'h2});
        wr_reg(16'hFFFF);
        $display("test probe codes done");
        repeat (24)
        begin
            w = 16'(rnd());
            wr_reg((w & MASKS[w[1:0]]) | {14'h0, w[1:0]});
        end
        $display("test random words done");
        // An unloaded word first; only the newest sixteen bits may count.
        u_host.send_word(16'hFFFE, 1'b0);
        wr_reg(16'h25A5);
        $display("test newest bits done");
        wr_reg(16'h0002);
        wr_reg(16'h00C0);
        check(auxPinOe, 1'b0);
        receiveOn <= 1'b0;
        repeat (6) @(posedge clock);
        check(auxPinOe, 1'b1);
        check_all();
        $display("test power control done");
        wr_reg(16'h0400);
        supplyLow <= 1'b1;
        repeat (6) @(posedge clock);
        check(lowvoltLockout, 1'b1);
        check(paEnableOut, 1'b0);
        supplyLow <= 1'b0;
        receiveOn <= 1'b1;
        repeat (6) @(posedge clock);
        check(lowvoltLockout, 1'b0);
        check(rfBufferOn, 1'b0);
        check(auxPinOe, 1'b1);
        $display("test lockout done");
        tally_and_finish();
    end
endmodule

bind radio_serial_control_regs rsc_regs_chk u_chk (.clock(clock),
    .reset(reset), .rxData(rxData), .probeSrc(probeSrc),
    .paEnableOut(paEnableOut), .rxDataOut(rxDataOut), .auxPinOut(auxPinOut),
    .auxPinOe(auxPinOe),
    .lowvoltLockout(lowvoltLockout), .rfBufferOn(rfBufferOn),
    .analogTestMode(analogTestMode), .digitalTestMode(digitalTestMode),
    .ctrl(ctrl));
`default_nettype wire
